// file: rtl/charger_cmd_master.sv
// Master end: runs word writes and word reads on software request.
`include "charger_defines.svh"
`default_nettype none
module charger_cmd_master #(
  parameter int QTR = `QTR_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  smbus_link_if.host link,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata
);
  // ----------------------------------------------------------------
  // Registers and sequencing
  // ----------------------------------------------------------------
  charger_pkg::hostState_t state_ff;
  logic [7:0] cmd_ff;
  logic [15:0] wdata_ff;
  logic [15:0] rdata_ff;
  logic [15:0] regRdata_ff;
  logic busy_ff;
  logic nack_ff;
  logic isRead_ff;
  logic [7:0] qCnt_ff;
  logic [1:0] phase_ff;
  logic [3:0] bitCnt_ff;
  logic [2:0] idx_ff;
  logic [7:0] rxShift_ff;
  logic ackBit_ff;
  logic sdaA_ff;
  logic sdaB_ff;
  logic sclOut_ff;
  logic sdaOe_ff;
  logic tick;
  logic go;
  logic hostTx;
  logic lastByte;
  logic [7:0] txByte;
  logic nxtScl;
  logic nxtOe;

  assign tick = (qCnt_ff == 8'(QTR - 1));
  assign go = regWr && (regAddr == `REG_CTRL) && regWdata[`CTRL_GO] && !busy_ff;
  assign hostTx = !(isRead_ff && idx_ff >= 3'h3);
  assign lastByte = isRead_ff ? (idx_ff == 3'h4) : (idx_ff == 3'h3);

  always_comb
  begin
    case (idx_ff)
      3'h0: txByte = {`DEV_ADDR, 1'b0};
      3'h1: txByte = cmd_ff;
      3'h2: txByte = isRead_ff ? {`DEV_ADDR, 1'b1} : wdata_ff[7:0];
      3'h3: txByte = wdata_ff[15:8];
      default: txByte = 8'hFF;
    endcase
  end

  // Data line is asynchronous to clk, so two flops before use.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sdaA_ff <= 1'b1;
      sdaB_ff <= 1'b1;
    end
    else
    begin
      sdaA_ff <= link.sda;
      sdaB_ff <= sdaA_ff;
    end
  end

  // Quarter-period timer for the divided clock.
  always_ff @(posedge clk)
  begin
    if (srst || go || tick)
      qCnt_ff <= 8'h00;
    else
      qCnt_ff <= qCnt_ff + 8'h01;
  end

  // Sample received bits in the middle of the high clock phase.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rxShift_ff <= 8'h00;
      ackBit_ff <= 1'b1;
    end
    else if (tick && phase_ff == 2'h1 && state_ff == charger_pkg::HST_BIT)
    begin
      if (bitCnt_ff < `BIT_ACK)
        rxShift_ff <= {rxShift_ff[6:0], sdaB_ff};
      else
        ackBit_ff <= sdaB_ff;
    end
  end

  // Frame sequencer: start, nine-bit bytes, stop.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_ff <= charger_pkg::HST_IDLE;
      phase_ff <= 2'h0;
      bitCnt_ff <= 4'h0;
      idx_ff <= 3'h0;
      busy_ff <= 1'b0;
      nack_ff <= 1'b0;
      isRead_ff <= 1'b0;
      rdata_ff <= 16'h0000;
    end
    else if (go)
    begin
      state_ff <= charger_pkg::HST_START;
      phase_ff <= 2'h0;
      idx_ff <= 3'h0;
      busy_ff <= 1'b1;
      nack_ff <= 1'b0;
      isRead_ff <= regWdata[`CTRL_READ];
    end
    else if (tick && state_ff != charger_pkg::HST_IDLE)
    begin
      phase_ff <= phase_ff + 2'h1;
      if (phase_ff == 2'h3)
      begin
        case (state_ff)
          charger_pkg::HST_START:
          begin
            state_ff <= charger_pkg::HST_BIT;
            bitCnt_ff <= 4'h0;
          end
          charger_pkg::HST_BIT:
          begin
            bitCnt_ff <= bitCnt_ff + 4'h1;
            if (bitCnt_ff == `BIT_ACK)
            begin
              bitCnt_ff <= 4'h0;
              if (idx_ff == 3'h3 && isRead_ff)
                rdata_ff[7:0] <= rxShift_ff;
              if (idx_ff == 3'h4)
                rdata_ff[15:8] <= rxShift_ff;
              if (hostTx && ackBit_ff)
              begin
                nack_ff <= 1'b1;
                state_ff <= charger_pkg::HST_STOP;
              end
              else if (lastByte)
                state_ff <= charger_pkg::HST_STOP;
              else if (isRead_ff && idx_ff == 3'h1)
                state_ff <= charger_pkg::HST_START;
              if (!lastByte)
                idx_ff <= idx_ff + 3'h1;
            end
          end
          charger_pkg::HST_STOP:
          begin
            state_ff <= charger_pkg::HST_IDLE;
            busy_ff <= 1'b0;
          end
          default: state_ff <= charger_pkg::HST_IDLE;
        endcase
      end
    end
  end

  // Line levels for each state and quarter.
  always_comb
  begin
    nxtScl = 1'b1;
    nxtOe = 1'b0;
    case (state_ff)
      // start: data falls while clock high
      charger_pkg::HST_START:
      begin
        nxtScl = (phase_ff == 2'h1) || (phase_ff == 2'h2);
        nxtOe = phase_ff[1];
      end
      charger_pkg::HST_BIT:
      begin
        nxtScl = (phase_ff == 2'h1) || (phase_ff == 2'h2);
        if (bitCnt_ff == `BIT_ACK)
          nxtOe = !hostTx && idx_ff == 3'h3;
        else
          nxtOe = hostTx && !txByte[3'h7 - bitCnt_ff[2:0]];
      end
      // stop: data rises while clock high
      charger_pkg::HST_STOP:
      begin
        nxtScl = (phase_ff != 2'h0);
        nxtOe = !phase_ff[1];
      end
      default:
      begin
        nxtScl = 1'b1;
        nxtOe = 1'b0;
      end
    endcase
  end

  // Registered pins keep both lines glitch free.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sclOut_ff <= 1'b1;
      sdaOe_ff <= 1'b0;
    end
    else
    begin
      sclOut_ff <= nxtScl;
      sdaOe_ff <= nxtOe;
    end
  end

  assign link.scl = sclOut_ff;
  assign link.hostSdaOe = sdaOe_ff;

  // Software register writes; ignored while a transfer runs.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cmd_ff <= 8'h00;
      wdata_ff <= 16'h0000;
    end
    else if (regWr && !busy_ff)
    begin
      if (regAddr == `REG_CMD)
        cmd_ff <= regWdata[7:0];
      if (regAddr == `REG_WDATA)
        wdata_ff <= regWdata;
    end
  end

  // Read data stands one cycle after the strobe.
  always_ff @(posedge clk)
  begin
    if (srst || !regRd)
      regRdata_ff <= 16'h0000;
    else
    begin
      case (regAddr)
        `REG_CMD: regRdata_ff <= {8'h00, cmd_ff};
        `REG_WDATA: regRdata_ff <= wdata_ff;
        `REG_STATUS: regRdata_ff <= {14'h0000, nack_ff, busy_ff};
        `REG_RDATA: regRdata_ff <= rdata_ff;
        default: regRdata_ff <= 16'h0000;
      endcase
    end
  end

  assign regRdata = regRdata_ff;
endmodule
`default_nettype wire

// file: rtl/charger_cmd_slave.sv
// Charger end: two-wire target that decodes mode and voltage commands.
`include "charger_defines.svh"
`default_nettype none
module charger_cmd_slave (
  input wire logic clk,
  input wire logic srst,
  smbus_link_if.device link,
  input wire logic batteryPresent,
  input wire logic thermistorHot,
  input wire logic thermistorUnderRange,
  output logic [15:0] modeWord,
  output logic [15:0] voltageSetpoint,
  output logic [15:0] currentSetpoint,
  output logic voltageOverRange,
  output logic chargeInhibited,
  output logic chargerOff,
  output logic [15:0] statusWord
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [4:0] syncA_ff;
  logic [4:0] syncB_ff;
  logic sclPrev_ff;
  logic sdaPrev_ff;
  logic scl;
  logic sda;
  logic batt;
  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;

  // Every pin is asynchronous to clk, so all pass two flops first.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      syncA_ff <= `SYNC_POR;
      syncB_ff <= `SYNC_POR;
    end
    else
    begin
      syncA_ff <= {thermistorUnderRange, thermistorHot, batteryPresent, link.sda, link.scl};
      syncB_ff <= syncA_ff;
    end
  end

  // Previous samples for edge and condition detection.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sclPrev_ff <= 1'b1;
      sdaPrev_ff <= 1'b1;
    end
    else
    begin
      sclPrev_ff <= syncB_ff[0];
      sdaPrev_ff <= syncB_ff[1];
    end
  end

  assign scl = syncB_ff[0];
  assign sda = syncB_ff[1];
  assign batt = syncB_ff[2];
  assign sclRise = scl && !sclPrev_ff;
  assign sclFall = !scl && sclPrev_ff;
  assign startCond = scl && sclPrev_ff && sdaPrev_ff && !sda;
  assign stopCond = scl && sclPrev_ff && !sdaPrev_ff && sda;

  // ----------------------------------------------------------------
  // Byte framing
  // ----------------------------------------------------------------
  charger_pkg::devState_t state_ff;
  logic [3:0] bitCnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] cmd_ff;
  logic [7:0] lowByte_ff;
  logic [15:0] statusLatch_ff;
  logic sdaOe_ff;
  logic byteDone;
  logic addrHit;
  logic wordDone;
  logic [15:0] word;
  logic [7:0] txByte;
  logic txBit;
  logic ackNow;

  assign byteDone = sclFall && (bitCnt_ff == `BIT_ACK);
  assign addrHit = (shift_ff[7:1] == `DEV_ADDR);
  assign wordDone = byteDone && (state_ff == charger_pkg::DEV_DHI);
  assign word = {shift_ff, lowByte_ff};
  assign txByte = (state_ff == charger_pkg::DEV_RDHI) ? statusLatch_ff[15:8] : statusLatch_ff[7:0];
  assign txBit = txByte[3'h7 - bitCnt_ff[2:0]];

  always_ff @(posedge clk)
  begin
    if (srst)
      state_ff <= charger_pkg::DEV_IDLE;
    else if (startCond)
      state_ff <= charger_pkg::DEV_ADDR;
    else if (stopCond)
      state_ff <= charger_pkg::DEV_IDLE;
    else if (byteDone)
    begin
      case (state_ff)
        charger_pkg::DEV_ADDR:
          state_ff <= !addrHit ? charger_pkg::DEV_SKIP :
                      shift_ff[0] ? charger_pkg::DEV_RDLO : charger_pkg::DEV_CMD;
        charger_pkg::DEV_CMD: state_ff <= charger_pkg::DEV_DLO;
        charger_pkg::DEV_DLO: state_ff <= charger_pkg::DEV_DHI;
        charger_pkg::DEV_DHI: state_ff <= charger_pkg::DEV_SKIP;
        default: state_ff <= state_ff;
      endcase
    end
    else if (sclRise && (bitCnt_ff == `BIT_ACK) && !sdaOe_ff)
    begin
      // The master acknowledges the low status byte to get the high one.
      // Our own address acknowledge is skipped, or it would pass for that ack.
      case (state_ff)
        charger_pkg::DEV_RDLO: state_ff <= sda ? charger_pkg::DEV_SKIP : charger_pkg::DEV_RDHI;
        charger_pkg::DEV_RDHI: state_ff <= charger_pkg::DEV_SKIP;
        default: state_ff <= state_ff;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst || startCond)
      bitCnt_ff <= 4'h0;
    else if (sclRise)
      bitCnt_ff <= (bitCnt_ff == `BIT_ACK) ? 4'h0 : bitCnt_ff + 4'h1;
  end

  // Data is sampled on the rising clock edge.
  always_ff @(posedge clk)
  begin
    if (srst)
      shift_ff <= 8'h00;
    else if (sclRise && (bitCnt_ff < `BIT_ACK))
      shift_ff <= {shift_ff[6:0], sda};
  end

  // Command, low data byte and status snapshot for the read.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cmd_ff <= 8'h00;
      lowByte_ff <= 8'h00;
      statusLatch_ff <= 16'h0000;
    end
    else if (byteDone)
    begin
      if (state_ff == charger_pkg::DEV_CMD)
        cmd_ff <= shift_ff;
      if (state_ff == charger_pkg::DEV_DLO)
        lowByte_ff <= shift_ff;
      // Snapshot keeps both bytes of one read coherent.
      if (state_ff == charger_pkg::DEV_ADDR)
        statusLatch_ff <= statusWord;
    end
  end

  assign ackNow = (state_ff == charger_pkg::DEV_ADDR && addrHit) ||
                  state_ff == charger_pkg::DEV_CMD || state_ff == charger_pkg::DEV_DLO ||
                  state_ff == charger_pkg::DEV_DHI;

  always_ff @(posedge clk)
  begin
    if (srst || startCond || stopCond)
      sdaOe_ff <= 1'b0;
    else if (sclFall)
    begin
      if (bitCnt_ff == `BIT_ACK)
        sdaOe_ff <= ackNow;
      else if (state_ff == charger_pkg::DEV_RDLO || state_ff == charger_pkg::DEV_RDHI)
        sdaOe_ff <= !txBit;
      else
        sdaOe_ff <= 1'b0;
    end
  end

  assign link.devSdaOe = sdaOe_ff;

  // ----------------------------------------------------------------
  // Command registers
  // ----------------------------------------------------------------
  logic [15:0] mode_ff;
  logic [15:0] volt_ff;
  logic [15:0] curr_ff;
  logic voltOr_ff;
  logic thermHot_ff;
  logic chargerOff_ff;
  logic [15:0] voltMasked;
  logic modeWrite;
  logic reload;

  assign voltMasked = word & `VOLT_MASK;
  assign modeWrite = wordDone && (cmd_ff == `CMD_MODE);
  assign reload = modeWrite && word[`MB_PORRST];

  // mask bits take reset values 0 and 1
  always_ff @(posedge clk)
  begin
    if (srst)
      mode_ff <= `MODE_POR;
    else
    begin
      if (modeWrite)
        mode_ff <= word;
      if (!batt)
        mode_ff[`MB_HOTSTOP] <= 1'b1;
    end
  end

  // The stored value is already clamped, so the loop never sees over-range.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      volt_ff <= `VOLT_POR;
      voltOr_ff <= 1'b0;
    end
    else if (!batt)
    begin
      volt_ff <= `VOLT_POR;
      voltOr_ff <= 1'b0;
    end
    else if (wordDone && (cmd_ff == `CMD_VOLT))
    begin
      volt_ff <= (voltMasked > `VOLT_POR) ? `VOLT_POR : voltMasked;
      voltOr_ff <= (voltMasked > `VOLT_POR);
    end
    else if (reload)
    begin
      volt_ff <= `VOLT_POR;
      voltOr_ff <= (`VOLT_RELOAD > `VOLT_POR);
    end
  end

  // Current has no command here; only reset, reload and removal touch it.
  always_ff @(posedge clk)
  begin
    if (srst || !batt || reload)
      curr_ff <= `CURR_POR;
  end

  // Hot flag is sticky; a new hot sample beats a reload clear.
  always_ff @(posedge clk)
  begin
    if (srst)
      thermHot_ff <= 1'b0;
    else if (syncB_ff[3])
      thermHot_ff <= 1'b1;
    else if (reload)
      thermHot_ff <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      chargerOff_ff <= 1'b1;
    else
      chargerOff_ff <= mode_ff[`MB_INHIBIT] || !batt ||
                       (mode_ff[`MB_HOTSTOP] && thermHot_ff);
  end

  assign modeWord = mode_ff;
  assign voltageSetpoint = volt_ff;
  assign currentSetpoint = curr_ff;
  assign voltageOverRange = voltOr_ff;
  assign chargeInhibited = mode_ff[`MB_INHIBIT];
  assign chargerOff = chargerOff_ff;

  // Status word as seen by a word read.
  always_comb
  begin
    statusWord = 16'h0000;
    statusWord[`ST_INHIBITED] = mode_ff[`MB_INHIBIT];
    statusWord[`ST_VOLT_OR] = voltOr_ff;
    statusWord[`ST_THERM_HOT] = thermHot_ff;
    statusWord[`ST_THERM_UR] = syncB_ff[4];
    statusWord[`ST_CHG_OFF] = chargerOff_ff;
    statusWord[`ST_BAT_PRESENT] = batt;
  end
endmodule
`default_nettype wire

// file: rtl/charger_defines.svh
// Shared constants for the charger command link and its two ends.
// Behaviour
// - Charger end only answers, never starts transfers.
// - Master opens transfers with data falling, clock high.
// - Master closes with data rising, clock high.
// - Eight data bits plus one acknowledge bit.
// - Data changes only while clock is low.
// - Charger answers fixed seven-bit address 0001001.
// - Commands use word write; status uses word read.
// - Command 0x12 loads the mode word.
// - Battery absent forces enable_a mode bit high.
// - Host clears enable_a only after battery insertion.
// - Command 0x15 loads the voltage set point.
// - Low four voltage bits are ignored.
// - Voltage set point resets to 0x47F0.
// - Over-limit voltage clamps and flags over-range.
// - Battery absent holds voltage at reset value.
// - Mode bit 0 inhibits charging and flags it.
// - Mode bit 2 reloads settings, clears flags; the code clears the hot flag but sets voltage over-range.
// - Mode bits 5, 6 mask presence, power-fail changes; the code only stores them.
// - Mode bit 10 lets flag_c stop charging.
`ifndef CHARGER_DEFINES_SVH
`define CHARGER_DEFINES_SVH
`define DEV_ADDR 7'h09
`define CMD_MODE 8'h12
`define CMD_VOLT 8'h15
`define MODE_POR 16'hFFD0
`define VOLT_POR 16'h47F0
`define VOLT_MASK 16'hFFF0
`define VOLT_RELOAD 16'hFFFF
`define CURR_POR 16'h0007
`define MB_INHIBIT 0
`define MB_PORRST 2
`define MB_HOTSTOP 10
`define ST_INHIBITED 0
`define ST_VOLT_OR 1
`define ST_THERM_HOT 2
`define ST_THERM_UR 3
`define ST_CHG_OFF 4
`define ST_BAT_PRESENT 14
`define BIT_ACK 4'h8
`define SYNC_POR 5'h03
`define CLK_PERIOD_NS 20
`define SCL_PERIOD_NS 640
`define QTR_CYCLES (`SCL_PERIOD_NS / (4 * `CLK_PERIOD_NS))
`define REG_CTRL 4'h0
`define REG_CMD 4'h1
`define REG_WDATA 4'h2
`define REG_STATUS 4'h3
`define REG_RDATA 4'h4
`define CTRL_GO 0
`define CTRL_READ 1
`endif

// file: rtl/charger_pkg.sv
// Types shared by the two ends of the charger command link.
`default_nettype none
package charger_pkg;
  typedef enum logic [7:0] {
    DEV_IDLE = 8'h01,
    DEV_ADDR = 8'h02,
    DEV_CMD = 8'h04,
    DEV_DLO = 8'h08,
    DEV_DHI = 8'h10,
    DEV_RDLO = 8'h20,
    DEV_RDHI = 8'h40,
    DEV_SKIP = 8'h80
  } devState_t;
  typedef enum logic [3:0] {
    HST_IDLE = 4'h1,
    HST_START = 4'h2,
    HST_BIT = 4'h4,
    HST_STOP = 4'h8
  } hostState_t;
endpackage
`default_nettype wire

// file: rtl/smbus_link_if.sv
// Two-wire link joining the charger end and the master end.
`default_nettype none
interface smbus_link_if;
  logic scl;
  logic devSdaOe;
  logic hostSdaOe;
  logic sda;
  // Open-drain data line: either end pulling low wins.
  assign sda = !(devSdaOe || hostSdaOe);
  modport device(input scl, input sda, output devSdaOe);
  modport host(output scl, output hostSdaOe, input sda);
endinterface
`default_nettype wire

// file: sim/charger_link_properties.sv
// Checker watching the two-wire link between the master end and the charger end.
`default_nettype none
module charger_link_properties (
  input wire logic clk,
  input wire logic srst,
  input wire logic scl,
  input wire logic sda,
  input wire logic devSdaOe,
  input wire logic hostSdaOe
);
  // ----------------------------------------
  // Frame tracking
  // ----------------------------------------
  logic sclQ_ff;
  logic sdaQ_ff;
  logic busy_ff;
  logic rdPhase_ff;
  logic addrOk_ff;
  logic [3:0] bitCnt_ff;
  logic [2:0] byteIdx_ff;
  logic [7:0] byteSh_ff;
  logic startSeen;
  logic stopSeen;
  logic sclRise;
  assign startSeen = sclQ_ff && scl && sdaQ_ff && !sda;
  assign stopSeen = sclQ_ff && scl && !sdaQ_ff && sda;
  assign sclRise = scl && !sclQ_ff;

  // Previous line levels, so edges are seen on the raw wires.
  always_ff @(posedge clk)
  begin
    sclQ_ff <= srst ? 1'b1 : scl;
    sdaQ_ff <= srst ? 1'b1 : sda;
  end

  // A start while busy is a repeated start, which opens the read half.
  always_ff @(posedge clk)
  begin
    if (srst || stopSeen)
    begin
      busy_ff <= 1'b0;
      rdPhase_ff <= 1'b0;
    end
    else if (startSeen)
    begin
      busy_ff <= 1'b1;
      rdPhase_ff <= busy_ff;
    end
  end

  // Bit and byte position; the ninth rise of a byte is its acknowledge.
  always_ff @(posedge clk)
  begin
    if (srst || startSeen)
    begin
      bitCnt_ff <= 4'h0;
      byteIdx_ff <= 3'h0;
      addrOk_ff <= 1'b0;
    end
    else if (sclRise && busy_ff && bitCnt_ff == 4'h8)
    begin
      bitCnt_ff <= 4'h0;
      byteIdx_ff <= (byteIdx_ff == 3'h7) ? byteIdx_ff : byteIdx_ff + 3'h1;
      addrOk_ff <= addrOk_ff || (byteIdx_ff == 3'h0 && byteSh_ff[7:1] == 7'h09);
    end
    else if (sclRise && busy_ff)
    begin
      bitCnt_ff <= bitCnt_ff + 4'h1;
      byteSh_ff <= {byteSh_ff[6:0], sda};
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence ackRise;
    sclRise && bitCnt_ff == 4'h8;
  endsequence
  sequence ackDrop;
    $fell(scl) && devSdaOe && !rdPhase_ff;
  endsequence

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  // Charger changes low.
  AST_DEV_CHANGE_LOW: assert property (
    $changed(devSdaOe) |-> !scl && !$past(scl)) else $error("charger data moved with clock high");
  AST_IDLE_QUIET: assert property (
    !busy_ff |-> !devSdaOe) else $error("charger drove data on an idle bus");
  AST_START_FORM: assert property (
    $rose(hostSdaOe) && !busy_ff |-> scl) else $error("frame opened with clock low");
  AST_STOP_IDLE: assert property (
    stopSeen |=> (scl && sda) [*4]) else $error("bus not released after stop");
  AST_ADDR_ACK: assert property (
    ackRise and byteIdx_ff == 3'h0 && byteSh_ff[7:1] == 7'h09 |-> devSdaOe)
    else $error("own address not acknowledged");
  AST_WRITE_ACK: assert property (
    ackRise and !rdPhase_ff && addrOk_ff && byteIdx_ff inside {[3'h1:3'h3]} |-> devSdaOe)
    else $error("written byte not acknowledged");
  AST_READ_NO_ACK: assert property (
    ackRise and rdPhase_ff && byteIdx_ff != 3'h0 |-> !devSdaOe)
    else $error("charger held data in the master acknowledge slot");
  AST_ACK_RELEASE: assert property (
    ackDrop |-> ##[2:8] !devSdaOe) else $error("acknowledge not released after clock fell");
endmodule
`default_nettype wire

// file: sim/charger_smbus_command_slave_tb.sv
// Testbench: master end drives word commands into the charger end over the link.
`include "charger_defines.svh"
`default_nettype none
module charger_smbus_command_slave_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // A write frame is about 1200 cycles, a read about 1500; twelve frames plus polling fit well below this.
  localparam int TIME_LIMIT = 60000;
  logic clk;
  logic srst;
  logic batteryPresent;
  logic thermistorHot;
  logic thermistorUnderRange;
  logic [3:0] regAddr;
  logic [15:0] regWdata;
  logic regWr;
  logic regRd;
  logic [15:0] regRdata;
  logic [15:0] modeWord;
  logic [15:0] voltageSetpoint;
  logic [15:0] currentSetpoint;
  logic voltageOverRange;
  logic chargeInhibited;
  logic chargerOff;
  logic [15:0] statusWord;
  logic prevScl;
  logic prevSda;
  logic [63:0] frameBits;
  logic [63:0] lastBits;
  int frameRises;
  int lastRises;
  int miscompares;
  int checked;
  int cycles;

  smbus_link_if smbus_link_if_inst ();
  charger_cmd_slave charger_cmd_slave_inst (.clk(clk), .srst(srst),
    .link(smbus_link_if_inst), .batteryPresent(batteryPresent),
    .thermistorHot(thermistorHot), .thermistorUnderRange(thermistorUnderRange),
    .modeWord(modeWord), .voltageSetpoint(voltageSetpoint), .currentSetpoint(currentSetpoint),
    .voltageOverRange(voltageOverRange), .chargeInhibited(chargeInhibited),
    .chargerOff(chargerOff), .statusWord(statusWord));
  charger_cmd_master #(.QTR(8)) charger_cmd_master_inst (.clk(clk), .srst(srst),
    .link(smbus_link_if_inst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata));
  charger_link_properties charger_link_properties_inst (.clk(clk), .srst(srst),
    .scl(smbus_link_if_inst.scl), .sda(smbus_link_if_inst.sda),
    .devSdaOe(smbus_link_if_inst.devSdaOe), .hostSdaOe(smbus_link_if_inst.hostSdaOe));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------
  // Wire monitor and watchdog
  // ----------------------------------------
  // Bits seen at each clock rise from start to stop, kept for comparison per frame.
  always @(posedge clk)
  begin
    prevScl <= smbus_link_if_inst.scl;
    prevSda <= smbus_link_if_inst.sda;
    if (prevScl && smbus_link_if_inst.scl && prevSda && !smbus_link_if_inst.sda)
    begin
      frameBits <= 64'h0;
      frameRises <= 0;
    end
    else if (prevScl && smbus_link_if_inst.scl && !prevSda && smbus_link_if_inst.sda)
    begin
      lastBits <= frameBits;
      lastRises <= frameRises;
    end
    else if (smbus_link_if_inst.scl && !prevScl)
    begin
      frameBits <= {frameBits[62:0], smbus_link_if_inst.sda};
      frameRises <= frameRises + 1;
    end
  end

  // A hang counts as a mismatch and closes the run.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == TIME_LIMIT)
    begin
      miscompares = miscompares + 1;
      end_sim();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked = checked + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic regWrite(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe; they are taken at the edge ending it.
  task automatic regRead(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
    d = regRdata;
  endtask

  task automatic waitIdle();
    logic [15:0] s;
    int n;
    s = 16'h0001;
    n = 0;
    while (s[0] !== 1'b0 && n < 5000)
    begin
      regRead(`REG_STATUS, s);
      n = n + 1;
    end
    check(s[1], 1'b0);
  endtask

  task automatic wordWrite(input logic [7:0] cmd, input logic [15:0] data);
    regWrite(`REG_CMD, {8'h00, cmd});
    regWrite(`REG_WDATA, data);
    regWrite(`REG_CTRL, 16'h0001);
    waitIdle();
    check(lastRises, 37);
    check(lastBits, {8'h12, 1'b0, cmd, 1'b0, data[7:0], 1'b0, data[15:8], 2'b00});
  endtask

  // The second segment carries the read address, low byte acked, high byte not acked.
  task automatic wordRead(input logic [7:0] cmd, input logic [15:0] exp);
    logic [15:0] d;
    regWrite(`REG_CMD, {8'h00, cmd});
    regWrite(`REG_CTRL, 16'h0003);
    waitIdle();
    regRead(`REG_RDATA, d);
    check(d, exp);
    check(lastRises, 28);
    check(lastBits, {8'h13, 1'b0, exp[7:0], 1'b0, exp[15:8], 2'b10});
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    srst = 1'b1;
    {batteryPresent, thermistorHot, thermistorUnderRange, regWr, regRd} = 5'h00;
    regAddr = 4'h0;
    regWdata = 16'h0000;
    {miscompares, checked, cycles, frameRises, lastRises} = {5{32'h0}};
    {prevScl, prevSda} = 2'b11;
    {frameBits, lastBits} = {2{64'h0}};
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    settle(4);
    check(modeWord, 16'hFFD0);
    check(voltageSetpoint, 16'h47F0);
    check(currentSetpoint, 16'h0007);
    check(statusWord, 16'h0010);
    batteryPresent <= 1'b1;
    settle(6);
    wordWrite(`CMD_VOLT, 16'h3001);
    check(voltageSetpoint, 16'h3000);
    wordWrite(`CMD_VOLT, 16'h47FF);
    check(voltageSetpoint, 16'h47F0);
    check(voltageOverRange, 1'b0);
    wordWrite(`CMD_VOLT, 16'h4800);
    check(voltageSetpoint, 16'h47F0);
    check(voltageOverRange, 1'b1);
    // Any command code returns the status word; zero is an arbitrary choice.
    wordRead(8'h00, 16'h4002);
    wordWrite(`CMD_MODE, 16'hFBD1);
    check(modeWord, 16'hFBD1);
    check({chargeInhibited, chargerOff, statusWord[0]}, 3'b111);
    wordWrite(`CMD_MODE, 16'hFBD0);
    check({chargeInhibited, chargerOff}, 2'b00);
    thermistorHot <= 1'b1;
    thermistorUnderRange <= 1'b1;
    settle(6);
    check(chargerOff, 1'b0);
    check(statusWord[3:2], 2'b11);
    wordWrite(`CMD_MODE, 16'hFFD0);
    check(chargerOff, 1'b1);
    thermistorHot <= 1'b0;
    thermistorUnderRange <= 1'b0;
    wordWrite(`CMD_VOLT, 16'h3000);
    wordWrite(`CMD_MODE, 16'hFFD4);
    check({voltageSetpoint, voltageOverRange}, {16'h47F0, 1'b1});
    check({currentSetpoint, statusWord[2]}, {16'h0007, 1'b0});
    wordWrite(`CMD_MODE, 16'hFBD0);
    wordWrite(`CMD_VOLT, 16'h3000);
    batteryPresent <= 1'b0;
    settle(6);
    check(voltageSetpoint, 16'h47F0);
    check(modeWord[10], 1'b1);
    check(statusWord[14], 1'b0);
    batteryPresent <= 1'b1;
    settle(6);
    wordWrite(`CMD_MODE, 16'hFBD0);
    check({modeWord[10], chargerOff}, 2'b00);
    end_sim();
  end
endmodule
`default_nettype wire
